// File: logic/fdl_host.sv
// fdl_host: host-side controller for a brushless fan driver
// assumes the flag and tach pins are asynchronous and the flag is pulled up externally
// Function
// [RULE1] driver conducts while switch input is high
// [RULE2] driver pulls flag low on overcurrent
// [RULE3] ignore flag during start-up interval
// [RULE4] flag fault reported as event
// [RULE5] one tach pulse per pole crossing
// [RULE6] no tach pulse during off-time
// [RULE7] speed from period between tach pulses
// [RULE8] drive switch input with PWM duty
// [RULE9] driver shuts down when overheated
// [RULE10] link is exactly three logic signals
// [RULE11] synchronise flag and tach first
`timescale 1ns/1ns
`default_nettype none
module fdl_host #(
  parameter int STARTUP_CYCLES = fdl_pkg::STARTUP_CYCLES,
  parameter int PWM_BITS = fdl_pkg::PWM_BITS
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic enable,
  input wire logic [PWM_BITS-1:0] duty,
  input wire logic fault_clear,
  input wire logic overcurrent_flag_n,
  input wire logic tach_in,
  output logic power_switch_in,
  output logic fault_event,
  output logic fault,
  output logic running,
  output fdl_pkg::fdl_speed_t speed
);
  typedef struct packed {
    fdl_pkg::fdl_mode_t mode;
    logic [PWM_BITS-1:0] pwm_cnt;
    logic drive;
    logic [31:0] start_cnt;
    logic [fdl_pkg::PERIOD_BITS-1:0] tach_cnt;
    logic tach_seen;
    logic fault_event;
    logic fault;
    logic run;
    fdl_pkg::fdl_speed_t speed;
  } fdl_host_t;
  fdl_host_t st;
  fdl_host_t next_st;
  logic flag_n_sync;
  logic flag_fall;
  logic tach_rise;

  fdl_sync #(
    .IDLE_LEVEL(1'b1)
  ) u_flag_sync ( // [RULE11]
    .clock(clock),
    .reset(reset),
    .d(overcurrent_flag_n),
    .q(flag_n_sync),
    .rise(),
    .fall(flag_fall)
  );

  fdl_sync #(
    .IDLE_LEVEL(1'b0)
  ) u_tach_sync ( // [RULE11]
    .clock(clock),
    .reset(reset),
    .d(tach_in),
    .q(),
    .rise(tach_rise),
    .fall()
  );

  function automatic logic [PWM_BITS-1:0] wrap_inc(input logic [PWM_BITS-1:0] v);
    wrap_inc = v + {{(PWM_BITS-1){1'b0}}, 1'b1};
  endfunction

  function automatic logic drive_mode(input fdl_pkg::fdl_mode_t m);
    drive_mode = (m == fdl_pkg::FDL_START) || (m == fdl_pkg::FDL_RUN);
  endfunction

  logic flag_active;
  assign flag_active = ~flag_n_sync;

  always_comb begin
    next_st = st;
    next_st.fault_event = 1'b0;
    next_st.pwm_cnt = wrap_inc(st.pwm_cnt);
    unique case (st.mode)
      fdl_pkg::FDL_IDLE: begin
        next_st.start_cnt = '0;
        if (enable) begin
          next_st.mode = fdl_pkg::FDL_START;
        end
      end
      fdl_pkg::FDL_START: begin
        next_st.start_cnt = st.start_cnt + 32'h00000001;
        if (!enable) begin
          next_st.mode = fdl_pkg::FDL_IDLE;
        end else if (st.start_cnt >= 32'(STARTUP_CYCLES - 1)) begin
          next_st.mode = fdl_pkg::FDL_RUN; // [RULE3]
        end
      end
      fdl_pkg::FDL_RUN: begin
        if (flag_active) begin // [RULE4]
          next_st.mode = fdl_pkg::FDL_FAULT;
          next_st.fault = 1'b1;
          next_st.fault_event = 1'b1;
        end else if (!enable) begin
          next_st.mode = fdl_pkg::FDL_IDLE;
        end
      end
      fdl_pkg::FDL_FAULT: begin
        if (fault_clear && !flag_active) begin
          next_st.fault = 1'b0;
          next_st.mode = fdl_pkg::FDL_IDLE;
        end
      end
    endcase
    // pwm compare; full scale duty stays on except at count max
    next_st.drive = drive_mode(next_st.mode) && (next_st.pwm_cnt < duty); // [RULE8]
    next_st.run = (next_st.mode == fdl_pkg::FDL_RUN);
    // tach period: pulses may be missing in off-time, so long gaps flag a stall
    if (tach_rise) begin // [RULE7]
      next_st.tach_cnt = '0;
      next_st.tach_seen = 1'b1;
      if (st.tach_seen) begin
        next_st.speed.period = st.tach_cnt;
        next_st.speed.period_valid = 1'b1;
        next_st.speed.stalled = 1'b0;
      end
    end else if (st.tach_cnt != fdl_pkg::PERIOD_MAX) begin
      next_st.tach_cnt = st.tach_cnt + {{(fdl_pkg::PERIOD_BITS-1){1'b0}}, 1'b1};
    end else begin
      next_st.speed.stalled = 1'b1;
      next_st.speed.period_valid = 1'b0;
      next_st.tach_seen = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign power_switch_in = st.drive; // [RULE10]
  assign fault_event = st.fault_event;
  assign fault = st.fault;
  assign running = st.run;
  assign speed = st.speed;

  chk_startup_ignores_flag: assert property (@(posedge clock) disable iff (reset) // [RULE3]
    (st.mode == fdl_pkg::FDL_START) |=> (st.mode != fdl_pkg::FDL_FAULT))
    else $error("flag acted on during start-up");

  sequence fault_entry;
    fault_event && fault && !power_switch_in;
  endsequence

  chk_flag_raises_fault: assert property (@(posedge clock) disable iff (reset) // [RULE4]
    (st.mode == fdl_pkg::FDL_RUN && flag_active) |=> fault_entry)
    else $error("flag in run did not raise fault");

  chk_fault_holds_off: assert property (@(posedge clock) disable iff (reset) // [RULE8]
    (st.mode == fdl_pkg::FDL_FAULT) |-> !power_switch_in)
    else $error("drive active while faulted");

  sequence tach_pair;
    tach_rise && st.tach_seen && st.tach_cnt != fdl_pkg::PERIOD_MAX;
  endsequence

  chk_period_capture: assert property (@(posedge clock) disable iff (reset) // [RULE7]
    tach_pair |=> (speed.period == $past(st.tach_cnt) && speed.period_valid))
    else $error("tach period not captured");

  chk_edge_from_sync: assert property (@(posedge clock) disable iff (reset) // [RULE11]
    flag_fall |-> !flag_n_sync && $past(flag_n_sync))
    else $error("flag edge not from synchronised level");

  chk_drive_idle_off: assert property (@(posedge clock) disable iff (reset) // [RULE8]
    !drive_mode(st.mode) |-> !power_switch_in)
    else $error("drive active outside start or run");

  chk_clear_refused: assert property (@(posedge clock) disable iff (reset) // [RULE4]
    (st.mode == fdl_pkg::FDL_FAULT && flag_active) |=> (st.mode == fdl_pkg::FDL_FAULT && fault))
    else $error("fault left while flag still low");

  chk_clear_taken: assert property (@(posedge clock) disable iff (reset) // [RULE4]
    (st.mode == fdl_pkg::FDL_FAULT && fault_clear && !flag_active) |=> (!fault && !running))
    else $error("fault clear not taken");

  sequence stall_hit;
    !tach_rise && st.tach_cnt == fdl_pkg::PERIOD_MAX;
  endsequence

  chk_stall_flag: assert property (@(posedge clock) disable iff (reset) // [RULE7]
    stall_hit |=> (speed.stalled && !speed.period_valid))
    else $error("saturated tach count did not flag stall");

  chk_start_to_run: assert property (@(posedge clock) disable iff (reset) // [RULE3]
    (st.mode == fdl_pkg::FDL_START && enable && st.start_cnt >= 32'(STARTUP_CYCLES - 1))
    |=> running)
    else $error("start-up interval did not end in run");

  chk_idle_to_start: assert property (@(posedge clock) disable iff (reset) // [RULE3]
    (st.mode == fdl_pkg::FDL_IDLE && enable) |=> (st.mode == fdl_pkg::FDL_START && !running))
    else $error("enable did not begin start-up");

  chk_first_tach_hold: assert property (@(posedge clock) disable iff (reset) // [RULE7]
    (tach_rise && !st.tach_seen) |=> $stable(speed.period))
    else $error("period captured from a single tach edge");

  chk_period_hold: assert property (@(posedge clock) disable iff (reset) // [RULE7]
    (!tach_rise && st.tach_cnt != fdl_pkg::PERIOD_MAX) |=> $stable(speed))
    else $error("speed changed without a tach edge");

  chk_event_one_cycle: assert property (@(posedge clock) disable iff (reset) // [RULE4]
    fault_event |=> !fault_event)
    else $error("fault event longer than one cycle");

  chk_enable_drop: assert property (@(posedge clock) disable iff (reset) // [RULE8]
    (st.mode == fdl_pkg::FDL_RUN && !enable && !flag_active) |=> (st.mode == fdl_pkg::FDL_IDLE))
    else $error("enable drop did not stop the fan");
endmodule
`default_nettype wire

// File: shared/fdl_pkg.sv
// fdl_pkg: constants and carrier types for the fan driver host controller
// assumes a 25 MHz system clock
package fdl_pkg;
  localparam int CLOCK_HZ = 25000000;
  localparam int PWM_BITS = 8;
  localparam int PERIOD_BITS = 24;
  localparam int STARTUP_MS = 500;
  localparam int STARTUP_CYCLES = (CLOCK_HZ / 1000) * STARTUP_MS;
  localparam int MIN_PULSE_US = 20;
  localparam int MIN_PULSE_CYCLES = (CLOCK_HZ / 1000000) * MIN_PULSE_US;
  localparam logic [7:0] PWM_DIV_RESET = 8'h00;
  localparam logic [PERIOD_BITS-1:0] PERIOD_MAX = 24'hFFFFFF;

  typedef enum logic [1:0] {
    FDL_IDLE = 2'b00,
    FDL_START = 2'b01,
    FDL_RUN = 2'b10,
    FDL_FAULT = 2'b11
  } fdl_mode_t;

  typedef struct packed {
    logic [PERIOD_BITS-1:0] period;
    logic period_valid;
    logic stalled;
  } fdl_speed_t;
endpackage

// File: logic/fdl_sync.sv
// fdl_sync: two-stage synchroniser with rising and falling edge pulses
// assumes d arrives asynchronously to clock
`timescale 1ns/1ns
`default_nettype none
module fdl_sync #(
  parameter logic IDLE_LEVEL = 1'b0
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic d,
  output logic q,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } fdl_sync_t;
  fdl_sync_t st;
  fdl_sync_t next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      // reset to the pin's idle level so no false edge follows reset
      st <= {3{IDLE_LEVEL}};
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;
  assign rise = st.s2 & ~st.s3;
  assign fall = ~st.s2 & st.s3;
endmodule
`default_nettype wire

// File: bench/fdl_dev_model.sv
// fdl_dev_model: behavioural fan driver seen from its three logic pins
// assumes the bench commands overcurrent, pole crossings and overheating
`timescale 1ns/1ns
`default_nettype none
module fdl_dev_model #(
  parameter int PULSE_NS = 20000
) (
  input wire logic power_switch_in,
  input wire logic over,
  input wire logic pole,
  input wire logic hot,
  output logic overcurrent_flag_n,
  output logic tach_in
);
  logic conducting;
  assign conducting = power_switch_in & ~hot;
  assign overcurrent_flag_n = ~(over & conducting);
  initial tach_in = 1'b0;
  always @(posedge pole) begin
    if (conducting) begin
      tach_in = 1'b1;
      #PULSE_NS tach_in = 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: bench/fan_driver_logic_interface_bench.sv
// fan_driver_logic_interface_bench: random and corner tests of the host controller
// assumes the device model stands on the far side of the three pins
`timescale 1ns/1ns
`default_nettype none
module fan_driver_logic_interface_bench;
  logic clock = 1'b0, reset = 1'b1, enable = 1'b0, fault_clear = 1'b0;
  logic over = 1'b0, pole = 1'b0, hot = 1'b0;
  logic [7:0] duty = 8'h00;
  logic psw, flag_n, tach, fev, flt, run;
  fdl_pkg::fdl_speed_t speed;
  int n_mismatch = 0, num_checks = 0, cyc = 0, k, p, h;
  always #20 clock = ~clock;
  fdl_host #(.STARTUP_CYCLES(50)) u_fdl_host (.clock(clock), .reset(reset), .enable(enable),
    .duty(duty), .fault_clear(fault_clear), .overcurrent_flag_n(flag_n), .tach_in(tach),
    .power_switch_in(psw), .fault_event(fev), .fault(flt), .running(run), .speed(speed));
  fdl_dev_model u_fdl_dev_model (.power_switch_in(psw), .over(over), .pole(pole), .hot(hot),
    .overcurrent_flag_n(flag_n), .tach_in(tach));
  task automatic stop_test;
    if (n_mismatch == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (e !== g) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic crossings(input int n, input int gap);
    repeat (n) begin
      pole = 1'b1;
      wait_n(1);
      pole = 1'b0;
      wait_n(gap - 1);
    end
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    k = $urandom(84073);
    wait_n(2);
    reset = 1'b0;
    chk("reset_outputs", 32'h0, {psw, fev, flt, run, speed.period_valid, speed.stalled});
    enable = 1'b1;
    duty = 8'hFF;
    over = 1'b1;
    wait_n(40);
    chk("startup_fault", 32'h0, {flt, run});
    over = 1'b0;
    wait_n(20);
    chk("running", 32'h1, run);
    p = 600 + 2 * int'($urandom % 100);
    crossings(3, p);
    chk("period", p - 1, speed.period);
    chk("period_valid", 32'h1, speed.period_valid);
    duty = 8'h00;
    wait_n(256);
    crossings(2, 700);
    chk("off_period", p - 1, speed.period);
    for (int i = 0; i < 7; i++) begin
      duty = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? 8'hFF : 8'($urandom);
      wait_n(256);
      h = 0;
      repeat (256) begin
        wait_n(1);
        h += int'(psw === 1'b1);
      end
      chk("duty_count", duty, h);
    end
    duty = 8'hFF;
    over = 1'b1;
    hot = 1'b1;
    wait_n(8);
    chk("hot_no_fault", 32'h0, flt);
    hot = 1'b0;
    k = 0;
    while (fev !== 1'b1 && k < 8) begin
      wait_n(1);
      k++;
    end
    chk("fault_event", 32'h1, fev);
    fault_clear = 1'b1;
    wait_n(1);
    chk("fault_state", 32'h2, {fev, flt, psw});
    chk("clear_refused", 32'h1, flt);
    over = 1'b0;
    wait_n(2);
    fault_clear = 1'b0;
    chk("fault_cleared", 32'h0, flt);
    stop_test();
  end
endmodule
`default_nettype wire
